// >>> iep_defs.svh
`ifndef IEP_DEFS_SVH
`define IEP_DEFS_SVH
`define IEP_OFF_CTRL 32'h0000_0000
`define IEP_OFF_STATUS 32'h0000_0004
`define IEP_OFF_IDT_LIMIT 32'h0000_0008
`define IEP_OFF_STACK_PTR 32'h0000_000c
`define IEP_CTRL_IF 0
`define IEP_CTRL_SS 1
`define IEP_CTRL_TS 2
`define IEP_CTRL_MP 3
`define IEP_CTRL_EM 4
`define IEP_CTRL_PE 5
`define IEP_CTRL_W 6
`define IEP_CTRL_RST 6'h00
`define IEP_IDT_RST 16'h03ff
`define IEP_SP_RST 32'h0000_0000
`define IEP_IDT_MIN 16'h000f
`define IEP_SP_MIN 32'h0000_0005
`define IEP_VEC_DEBUG 8'h01
`define IEP_VEC_NMI 8'h02
`define IEP_VEC_UD 8'h06
`define IEP_VEC_NM 8'h07
`define IEP_VEC_GP 8'h0d
`define IEP_VEC_PF 8'h0e
`define IEP_VEC_MF 8'h10
`define IEP_VEC_AC 8'h11
`define IEP_LVL_REAL 2'h0
`endif

// >>> iep_pkg.sv
package iep_pkg;
	typedef enum logic [1:0] {
		IEP_RUN = 2'h0,
		IEP_ACK = 2'h1,
		IEP_HALT = 2'h3,
		IEP_SHUT = 2'h2
	} iep_state_e;

	typedef enum logic [3:0] {
		IEP_EV_NONE, IEP_EV_DBG_PREV, IEP_EV_DBG_NEXT, IEP_EV_NMI, IEP_EV_MASKABLE_REQUEST,
		IEP_EV_FETCH, IEP_EV_DECODE, IEP_EV_WAIT_NA, IEP_EV_ESC_NA, IEP_EV_CERR,
		IEP_EV_SEG, IEP_EV_PAGE, IEP_EV_ALIGN, IEP_EV_SWI, IEP_EV_HALT, IEP_EV_SHUT
	} iep_evt_e;

	typedef struct packed {
		logic boundary;
		logic string_window;
		logic interrupt_return;
		logic halt_instruction;
		logic severe_error;
		logic swi_valid;
		logic [7:0] swi_vector;
		logic dbg_prev;
		logic dbg_next;
		logic fetch_fault;
		logic [7:0] fetch_vector;
		logic decode_fault;
		logic wait_inst;
		logic esc_inst;
		logic seg_fault;
		logic page_fault;
		logic align_fault;
		logic partial_task_segment;
		logic cs_load;
		logic [1:0] cs_descriptor_level;
		logic mem_check;
		logic code_call;
		logic [1:0] requested_level;
		logic [1:0] descriptor_level;
	} iep_core_s;

	typedef struct packed {
		logic valid;
		logic [7:0] vector;
		logic trap;
		logic restartable;
	} iep_disp_s;
endpackage

// >>> iep_unit.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "iep_defs.svh"
module iep_unit (
	input wire logic ref_clk, // Core clock
	input wire logic reset_n, // Async reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic nmi_pin, // Non-maskable request pin
	input wire logic maskable_request, // Maskable request pin
	input wire logic coproc_error_n, // Coprocessor error pin
	input wire logic ack_valid, // Vector valid from controller
	input wire logic [7:0] ack_vector, // Vector from controller
	output logic ack_req, // Acknowledge cycle request
	input iep_pkg::iep_core_s core, // Core boundary info
	output iep_pkg::iep_disp_s disp, // Dispatch pulse
	output logic halted, // Halt state
	output logic shutdown, // Shutdown state
	output logic bus_released, // Local bus released
	output logic gp_fault, // Privilege check failed
	output logic [1:0] current_level // Current privilege level
);
	import iep_pkg::*;

	logic [3:0] pin_raw;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic nmi_s;
	logic maskable_request_s;
	logic cerr_s;
	logic ackv_s;
	logic ackv_prev;
	logic ack_rise;

	logic nmi_prev;
	logic nmi_edge;
	logic nmi_pend;
	logic nmi_busy;

	logic [`IEP_CTRL_W-1:0] ctrl;
	logic [15:0] idt_limit;
	logic [31:0] stack_ptr;
	logic [1:0] cs_level;
	logic [7:0] last_vector;

	iep_state_e state;
	iep_evt_e evt;
	logic [7:0] evt_vec;
	logic evt_trap;
	logic if_flag;
	logic real_mode;
	logic [1:0] cpl_eff;
	logic [1:0] eff_level;
	logic priv_fail;
	logic nmi_take;
	logic halt_wake_maskable_request;
	logic shut_exit;
	logic idt_fits;
	logic stack_fits;

	logic wr_en;
	logic rd_setup;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [31:0] status_word;

	assign pin_raw = {ack_valid, ~coproc_error_n, maskable_request, nmi_pin};

	// Two-stage synchronisers for every pin from outside the core clock except the ack_vector bus
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
				end else begin
					sync1[g] <= pin_raw[g];
					sync2[g] <= sync1[g];
				end
			end
		end
	endgenerate

	assign nmi_s = sync2[0];
	assign maskable_request_s = sync2[1];
	assign cerr_s = sync2[2];
	assign ackv_s = sync2[3];
	assign nmi_edge = nmi_s & ~nmi_prev;
	assign if_flag = ctrl[`IEP_CTRL_IF];
	assign real_mode = ~ctrl[`IEP_CTRL_PE];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			nmi_prev <= 1'b0;
		end else begin
			nmi_prev <= nmi_s;
		end
	end

	// Vector strobe edge: a valid still draining through the synchroniser
	// from the last acknowledge must not answer a new one
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ackv_prev <= 1'b0;
		end else begin
			ackv_prev <= ackv_s;
		end
	end

	assign ack_rise = ackv_s & ~ackv_prev;

	// NMI latch: a new edge wins over the service take in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			nmi_pend <= 1'b0;
		end else if (nmi_edge) begin
			nmi_pend <= 1'b1;
		end else if (nmi_take) begin
			nmi_pend <= 1'b0;
		end
	end

	// In-service flag; only an interrupt return or reset reopens NMI
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			nmi_busy <= 1'b0;
		end else if (nmi_take) begin
			nmi_busy <= 1'b1;
		end else if (core.interrupt_return) begin
			nmi_busy <= 1'b0;
		end
	end

	// Privilege levels
	assign cpl_eff = real_mode ? `IEP_LVL_REAL : cs_level;
	assign eff_level = (core.requested_level > cpl_eff) ? core.requested_level : cpl_eff;
	// Real mode keeps the checks; only the current level is forced to zero
	always_comb begin
		if (core.code_call) begin
			priv_fail = cpl_eff < core.descriptor_level;
		end else begin
			priv_fail = eff_level > core.descriptor_level;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_level <= `IEP_LVL_REAL;
		end else if (core.cs_load) begin
			cs_level <= core.cs_descriptor_level;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gp_fault <= 1'b0;
			current_level <= `IEP_LVL_REAL;
		end else begin
			gp_fault <= core.mem_check & priv_fail;
			current_level <= cpl_eff;
		end
	end

	// Arbitration: one winner per boundary, the rest stay pending
	always_comb begin
		evt = IEP_EV_NONE;
		evt_vec = 8'h00;
		evt_trap = 1'b0;
		if (state == IEP_RUN && (core.boundary || core.string_window)) begin
			// Severe error outranks every listed level; after it only an NMI is serviced, once the IDT limit and stack pointer fit
			if (core.boundary && core.severe_error) begin
				evt = IEP_EV_SHUT;
			end else if (core.boundary && (core.dbg_prev || ctrl[`IEP_CTRL_SS])) begin
				evt = IEP_EV_DBG_PREV;
				evt_vec = `IEP_VEC_DEBUG;
				evt_trap = 1'b1;
			end else if (core.boundary && core.dbg_next) begin
				evt = IEP_EV_DBG_NEXT;
				evt_vec = `IEP_VEC_DEBUG;
			end else if (nmi_pend && !nmi_busy) begin
				evt = IEP_EV_NMI;
				evt_vec = `IEP_VEC_NMI;
				evt_trap = 1'b1;
			end else if (maskable_request_s && if_flag) begin
				evt = IEP_EV_MASKABLE_REQUEST;
			end else if (!core.boundary) begin
				evt = IEP_EV_NONE;
			end else if (core.fetch_fault) begin
				evt = IEP_EV_FETCH;
				evt_vec = core.fetch_vector;
			end else if (core.decode_fault) begin
				evt = IEP_EV_DECODE;
				evt_vec = `IEP_VEC_UD;
			end else if (core.wait_inst && ctrl[`IEP_CTRL_TS] && ctrl[`IEP_CTRL_MP]) begin
				evt = IEP_EV_WAIT_NA;
				evt_vec = `IEP_VEC_NM;
			end else if (core.esc_inst && (ctrl[`IEP_CTRL_EM] || ctrl[`IEP_CTRL_TS])) begin
				evt = IEP_EV_ESC_NA;
				evt_vec = `IEP_VEC_NM;
			end else if (cerr_s) begin
				evt = IEP_EV_CERR;
				evt_vec = `IEP_VEC_MF;
			end else if (core.seg_fault) begin
				evt = IEP_EV_SEG;
				evt_vec = `IEP_VEC_GP;
			end else if (core.page_fault) begin
				evt = IEP_EV_PAGE;
				evt_vec = `IEP_VEC_PF;
			end else if (core.align_fault) begin
				evt = IEP_EV_ALIGN;
				evt_vec = `IEP_VEC_AC;
			end else if (core.swi_valid) begin
				evt = IEP_EV_SWI;
				evt_vec = core.swi_vector;
				evt_trap = 1'b1;
			end else if (core.halt_instruction) begin
				evt = IEP_EV_HALT;
			end
		end
	end

	// Halt wakes on an enabled maskable request even while an NMI is in service
	assign halt_wake_maskable_request = maskable_request_s && if_flag;
	assign idt_fits = idt_limit >= `IEP_IDT_MIN;
	assign stack_fits = stack_ptr > `IEP_SP_MIN;
	assign shut_exit = idt_fits && stack_fits;
	always_comb begin
		case (state)
			IEP_RUN: nmi_take = (evt == IEP_EV_NMI);
			IEP_HALT: nmi_take = nmi_pend && !nmi_busy;
			IEP_SHUT: nmi_take = nmi_pend && !nmi_busy && shut_exit;
			default: nmi_take = 1'b0;
		endcase
	end

	// Control state machine and dispatch
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= IEP_RUN;
			disp <= '0;
			ack_req <= 1'b0;
			last_vector <= 8'h00;
		end else begin
			disp <= '0;
			case (state)
				IEP_RUN: begin
					if (evt == IEP_EV_SHUT) begin
						state <= IEP_SHUT;
					end else if (evt == IEP_EV_HALT) begin
						state <= IEP_HALT;
					end else if (evt == IEP_EV_MASKABLE_REQUEST) begin
						state <= IEP_ACK;
						ack_req <= 1'b1;
					end else if (evt != IEP_EV_NONE) begin
						disp.valid <= 1'b1;
						disp.vector <= evt_vec;
						disp.trap <= evt_trap;
						disp.restartable <= !evt_trap && !core.partial_task_segment;
						last_vector <= evt_vec;
					end
				end
				IEP_ACK: begin
					if (ack_rise) begin
						// Controller must hold the vector stable while valid is high
						ack_req <= 1'b0;
						state <= IEP_RUN;
						disp.valid <= 1'b1;
						disp.vector <= ack_vector;
						disp.trap <= 1'b1;
						last_vector <= ack_vector;
					end
				end
				IEP_HALT: begin
					if (nmi_take) begin
						state <= IEP_RUN;
						disp.valid <= 1'b1;
						disp.vector <= `IEP_VEC_NMI;
						disp.trap <= 1'b1;
						last_vector <= `IEP_VEC_NMI;
					end else if (halt_wake_maskable_request) begin
						state <= IEP_ACK;
						ack_req <= 1'b1;
					end
				end
				IEP_SHUT: begin
					if (nmi_take) begin
						state <= IEP_RUN;
						disp.valid <= 1'b1;
						disp.vector <= `IEP_VEC_NMI;
						disp.trap <= 1'b1;
						last_vector <= `IEP_VEC_NMI;
					end
				end
				default: state <= IEP_RUN;
			endcase
		end
	end

	// Status outputs trail the state by one cycle so that each comes from a flop
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			halted <= 1'b0;
			shutdown <= 1'b0;
			bus_released <= 1'b0;
		end else begin
			halted <= (state == IEP_HALT);
			shutdown <= (state == IEP_SHUT);
			bus_released <= (state == IEP_HALT);
		end
	end

	// APB slave, one wait-free access phase
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_setup = psel && !penable;
	assign status_word = {
		15'h0000,
		gp_fault,
		last_vector,
		2'h0,
		cpl_eff,
		state == IEP_SHUT,
		state == IEP_HALT,
		nmi_pend,
		nmi_busy
	};

	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (paddr == `IEP_OFF_CTRL) begin
			next_prdata = {26'h0000000, ctrl};
		end else if (paddr == `IEP_OFF_STATUS) begin
			next_prdata = status_word;
		end else if (paddr == `IEP_OFF_IDT_LIMIT) begin
			next_prdata = {16'h0000, idt_limit};
		end else if (paddr == `IEP_OFF_STACK_PTR) begin
			next_prdata = stack_ptr;
		end else begin
			next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= rd_setup;
			pslverr <= rd_setup && next_pslverr;
			prdata <= (rd_setup && !pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	// Status is read-only: a write to it completes and is ignored, not refused
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= `IEP_CTRL_RST;
			idt_limit <= `IEP_IDT_RST;
			stack_ptr <= `IEP_SP_RST;
		end else if (wr_en) begin
			if (paddr == `IEP_OFF_CTRL) begin
				ctrl <= pwdata[`IEP_CTRL_W-1:0];
			end else if (paddr == `IEP_OFF_IDT_LIMIT) begin
				idt_limit <= pwdata[15:0];
			end else if (paddr == `IEP_OFF_STACK_PTR) begin
				stack_ptr <= pwdata;
			end
		end
	end
endmodule

// >>> iep_unit_properties.sv
`timescale 1ns/10ps
module iep_unit_properties
	import iep_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [31:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic ack_req, // Ack request
	input wire logic [7:0] ack_vector, // Vector in
	input iep_pkg::iep_core_s core, // Core info
	input iep_pkg::iep_disp_s disp, // Dispatch
	input wire logic halted, // Halt
	input wire logic shutdown, // Shutdown
	input wire logic bus_released, // Bus free
	input wire logic gp_fault, // Fault
	input wire logic [1:0] current_level // Level
);
	logic ss;
	logic [1:0] effective_level;
	logic gp_due;
	assign effective_level = core.requested_level > current_level ? core.requested_level : current_level;
	assign gp_due = core.code_call ? current_level < core.descriptor_level
		: effective_level > core.descriptor_level;
	// Shadow of the single-step bit, the one control bit these checks need
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			ss <= 1'b0;
		else if (psel && penable && pready && pwrite && !pslverr && paddr == 32'h0)
			ss <= pwdata[1];
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_vec(logic [7:0] v);
		disp.valid && disp.vector == v;
	endsequence
	sequence s_run_edge;
		core.boundary && !core.severe_error && !halted && !shutdown && !ack_req;
	endsequence
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_APB_ERR: assert property (pslverr |-> pready)
		else $error("pslverr outside access");
	AST_DISP_ONE: assert property (disp.valid |=> !disp.valid)
		else $error("dispatch longer than one cycle");
	AST_ACK_VEC: assert property ($fell(ack_req) |-> s_vec($past(ack_vector)))
		else $error("acknowledge ended without its vector");
	AST_BUS_FREE: assert property (bus_released == halted)
		else $error("bus release differs from halt");
	AST_GP_SET: assert property (core.mem_check |=> gp_fault == $past(gp_due))
		else $error("privilege check result wrong");
	AST_GP_PULSE: assert property (!core.mem_check |=> !gp_fault)
		else $error("fault without check");
	AST_SINGLE_STEP: assert property (s_run_edge ##0 ss |=> s_vec(8'h01) ##0 disp.trap)
		else $error("single-step trap missing");
endmodule
bind iep_unit iep_unit_properties i_chk (.*);

// >>> iep_pic_model.sv
`timescale 1ns/10ps
module iep_pic_model (
	input wire logic ref_clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic ack_req, // Ack request
	input wire logic [7:0] vec_cfg, // Vector to give
	input wire logic [3:0] delay_cfg, // Answer delay
	output logic ack_valid, // Vector valid
	output logic [7:0] ack_vector // Vector
);
	logic [3:0] cnt;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 4'h0;
			ack_valid <= 1'b0;
			ack_vector <= 8'h00;
		end else if (ack_valid) begin
			if (!ack_req) begin
				ack_valid <= 1'b0;
				ack_vector <= ~ack_vector;
			end
		end else if (ack_req && cnt == delay_cfg) begin
			cnt <= 4'h0;
			ack_valid <= 1'b1;
			ack_vector <= vec_cfg;
		end else begin
			cnt <= ack_req ? cnt + 4'h1 : 4'h0;
			// Idle vector keeps moving so a stale value never looks fresh
			ack_vector <= ~ack_vector;
		end
	end
endmodule

// >>> iep_unit_tb.sv
`timescale 1ns/10ps
module iep_unit_tb;
	import iep_pkg::*;
	logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic nmi_pin, maskable_request, coproc_error_n, ack_valid, ack_req;
	logic halted, shutdown, bus_released, gp_fault;
	logic [1:0] current_level;
	logic [7:0] ack_vector, vec_cfg;
	logic [3:0] delay_cfg;
	iep_core_s core, c;
	iep_disp_s disp;
	int n_fail, checks_done;
	logic [31:0] regs [5] = '{32'h0, 32'h0, 32'h3ff, 32'h0, 32'h0};
	logic [7:0] fv [7] = '{8'h06, 8'h0e, 8'h07, 8'h07, 8'h0d, 8'h0e, 8'h11};
	logic [4:0] pv [5] = '{5'h1d, 5'h00, 5'h03, 5'h0c, 5'h1e};
	iep_unit i_dut (.*);
	iep_pic_model i_pic (.*);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic go(logic b = 1'b1);
		c.boundary = b;
		core <= c;
		@(posedge ref_clk);
		core <= '0;
		c = '0;
	endtask
	task automatic exp_disp(logic [7:0] v, logic t);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (disp.valid !== 1'b1 && n < 40);
		chk("disp_valid", disp.valid, 1'b1);
		chk("vector", disp.vector, v);
		chk("trap", disp.trap, t);
	endtask
	task automatic none(int k);
		repeat (k) begin
			@(posedge ref_clk);
			chk("no_disp", disp.valid, 1'b0);
		end
	endtask
	// Pin edge plus synchroniser delay, so the request is pending on return
	task automatic nmi;
		nmi_pin <= 1'b1;
		repeat (2) @(posedge ref_clk);
		nmi_pin <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic close_out;
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		close_out;
	end
	initial begin
		{reset_n, psel, penable, pwrite, nmi_pin, maskable_request} = '0;
		coproc_error_n = 1'b1;
		paddr = '0;
		pwdata = '0;
		core = '0;
		c = '0;
		vec_cfg = 8'h47;
		delay_cfg = 4'h3;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 32'(i * 4), 32'h0);
			chk("reg", rd, regs[i]);
			chk("err", err, 32'(i == 4));
		end
		apb(1'b1, 32'h0, 32'h0000_000c);
		for (int i = 0; i < 7; i++) begin
			c.fetch_vector = 8'h0e;
			case (i)
			0: c.decode_fault = 1'b1;
			1: {c.fetch_fault, c.decode_fault} = 2'b11;
			2: {c.wait_inst, c.seg_fault} = 2'b11;
			3: {c.esc_inst, c.seg_fault} = 2'b11;
			4: {c.seg_fault, c.page_fault} = 2'b11;
			5: {c.page_fault, c.align_fault} = 2'b11;
			default: c.align_fault = 1'b1;
			endcase
			go;
			exp_disp(fv[i], 1'b0);
			chk("restart", disp.restartable, 1'b1);
		end
		apb(1'b1, 32'h0, 32'h0000_0010);
		{c.esc_inst, c.seg_fault} = 2'b11;
		go;
		exp_disp(8'h07, 1'b0);
		{c.wait_inst, c.seg_fault} = 2'b11;
		go;
		exp_disp(8'h0d, 1'b0);
		{c.decode_fault, c.partial_task_segment} = 2'b11;
		go;
		exp_disp(8'h06, 1'b0);
		chk("restart", disp.restartable, 1'b0);
		coproc_error_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		c.seg_fault = 1'b1;
		go;
		exp_disp(8'h10, 1'b0);
		coproc_error_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		{c.swi_valid, c.swi_vector} = 9'h180;
		go;
		exp_disp(8'h80, 1'b1);
		{c.dbg_next, c.decode_fault} = 2'b11;
		go;
		exp_disp(8'h01, 1'b0);
		chk("restart", disp.restartable, 1'b1);
		{c.dbg_prev, c.dbg_next} = 2'b11;
		go;
		exp_disp(8'h01, 1'b1);
		{c.string_window, c.decode_fault} = 2'b11;
		go(1'b0);
		none(3);
		apb(1'b1, 32'h0, 32'h0000_0002);
		c.decode_fault = 1'b1;
		go;
		exp_disp(8'h01, 1'b1);
		apb(1'b1, 32'h0, 32'h0);
		maskable_request <= 1'b1;
		repeat (3) @(posedge ref_clk);
		go;
		none(6);
		chk("ack_req", ack_req, 1'b0);
		apb(1'b1, 32'h0, 32'h0000_0001);
		nmi;
		go;
		exp_disp(8'h02, 1'b1);
		chk("ack_req", ack_req, 1'b0);
		c.string_window = 1'b1;
		go(1'b0);
		exp_disp(8'h47, 1'b1);
		maskable_request <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nmi;
		c.decode_fault = 1'b1;
		go;
		exp_disp(8'h06, 1'b0);
		c.interrupt_return = 1'b1;
		go(1'b0);
		go;
		exp_disp(8'h02, 1'b1);
		c.interrupt_return = 1'b1;
		go(1'b0);
		c.halt_instruction = 1'b1;
		go;
		repeat (3) @(posedge ref_clk);
		chk("halted", halted, 1'b1);
		chk("bus", bus_released, 1'b1);
		c.decode_fault = 1'b1;
		go;
		none(4);
		nmi_pin <= 1'b1;
		exp_disp(8'h02, 1'b1);
		nmi_pin <= 1'b0;
		@(posedge ref_clk);
		chk("halted", halted, 1'b0);
		c.interrupt_return = 1'b1;
		go(1'b0);
		vec_cfg <= 8'hff;
		delay_cfg <= 4'h0;
		c.halt_instruction = 1'b1;
		go;
		repeat (3) @(posedge ref_clk);
		maskable_request <= 1'b1;
		exp_disp(8'hff, 1'b1);
		maskable_request <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("level", current_level, 2'h0);
		for (int i = 0; i < 5; i++) begin
			if (i == 2) begin
				apb(1'b1, 32'h0, 32'h0000_0020);
				{c.cs_load, c.cs_descriptor_level} = 3'b110;
				go(1'b0);
				repeat (2) @(posedge ref_clk);
				chk("level", current_level, 2'h2);
			end
			{c.mem_check, c.requested_level, c.descriptor_level} = {1'b1, pv[i][4:1]};
			go(1'b0);
			@(posedge ref_clk);
			chk("gp", gp_fault, pv[i][0]);
		end
		for (int i = 0; i < 2; i++) begin
			{c.mem_check, c.code_call, c.descriptor_level} = {2'b11, 2'(3 - 2 * i)};
			go(1'b0);
			@(posedge ref_clk);
			chk("gp_call", gp_fault, 32'(i == 0));
		end
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 32'h8, {28'h0, 3'h7, i != 0});
			apb(1'b1, 32'hc, 32'(5 + (i != 1)));
			c.severe_error = 1'b1;
			go;
			repeat (3) @(posedge ref_clk);
			chk("shut", shutdown, 1'b1);
			nmi_pin <= 1'b1;
			if (i == 2)
				exp_disp(8'h02, 1'b1);
			else
				none(8);
			@(posedge ref_clk);
			chk("shut", shutdown, 32'(i != 2));
			nmi_pin <= 1'b0;
			reset_n <= 1'b0;
			@(posedge ref_clk);
			reset_n <= 1'b1;
			@(posedge ref_clk);
			chk("shut", shutdown, 1'b0);
		end
		close_out;
	end
endmodule
